// ---- tws_consts.vh ----
// register map, field positions and reset values of the three-wire serial port
// assumes inclusion by the port's rtl file only
`ifndef TWS_CONSTS_VH
`define TWS_CONSTS_VH

// register indexes, byte address is four times the index
`define TWS_IDX_CTRL 16'hff80
`define TWS_IDX_CKSEL 16'hff81
`define TWS_IDX_TXBUF 16'hff82
`define TWS_IDX_SHIFT 16'hff83
`define TWS_IDX_IRQ_STAT 16'hff84
`define TWS_IDX_IRQ_MASK 16'hff85

// serial_mode_control fields
`define TWS_CTRL_EN 7
`define TWS_CTRL_TRMD 6
`define TWS_CTRL_DIR 4
`define TWS_CTRL_BUSY 0

// serial_clock_select fields
`define TWS_CK_CKP 4
`define TWS_CK_DAP 3
`define TWS_CK_SEL_HI 2
`define TWS_CK_SEL_LO 0
`define TWS_CK_SLAVE 3'h7

// reset values
`define TWS_RST_BYTE 8'h00
`define TWS_RST_WORD 32'h0000_0000

// one word is eight bits, so sixteen clock edges
`define TWS_LAST_EDGE 4'hf
`define TWS_DIV_W 7

`endif

// ---- tws_serial_port.v ----
// three-wire clocked serial port with classic wishbone register slave
// assumes one 25 mhz clock, an active-low async reset, and an outside pad
// that resolves the clock pin from its output enable
//
// Overview of operation
// - eight-bit words move over one clock and two data lines, full duplex possible
// - first-bit select 0 sends and receives msb first, 1 lsb first
// - with enable and transmit mode set, a transmit buffer write starts a transfer
// - transmit buffer word loads the shift register and shifts out on data out
// - with transmit mode clear, reading the shift register starts receive-only transfer
// - bits on the data input pin shift in, one per serial clock
// - enable 0 disables and resets status flag and shift register; 1 enables
// - with transmit mode clear the data output pin stays low
// - read-only status flag at control bit 0 shows a transfer in progress
// - clock select 000 to 110 divides by 2 to 128; 111 is slave
// - polarity and phase bits pick four timing types; type 1 after reset
`include "tws_consts.vh"

// register map seen over the bus
// - control at word ff80: enable, transmit mode, first-bit select, busy flag
// - clock select at word ff81: polarity, phase, rate code
// - transmit buffer at word ff82, shift register at word ff83
// - transfer-end status at word ff84, its mask at word ff85
// every register sits in bits 7:0 of its word; upper bits read zero
//
// bus timing
// - a request is taken at the first edge with cyc and stb high and ack low
// - ack stands for exactly one cycle, so the master must drop stb after it
// - writes and transfer starts take effect at the edge that raises ack
//
// link timing types
// - polarity sets the level the clock rests at between words
// - phase 0 samples on leading edges and drives on trailing ones
// - phase 1 drives on leading edges and samples on trailing ones
// - a word is sixteen clock edges, counted in edge_r from zero
//
// slave mode hazards
// - the pin clock is synchronised, so it must stay well below clk / 4
// - data in passes the same two flops, keeping it aligned with the clock
// - edges are only counted while busy, so stray pin toggles are ignored
//
// limitation: the disable reset acts at the next clk edge, not at once,
// which keeps every flop on one clean asynchronous reset only

module tws_serial_port (
    // clock and reset
    input wire clk,
    input wire resetn,
    // wishbone slave
    input wire [17:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    input wire [3:0] wb_sel_i,
    input wire wb_we_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    output wire wb_ack_o,
    // interrupt
    output wire irq,
    // serial pins
    input wire serial_clock_pin_i,
    output wire serial_clock_pin_o,
    output wire serial_clock_pin_oe_n,
    input wire serial_data_in_pin,
    output wire serial_data_out_pin
);

    // registers
    reg ack_r;
    reg [31:0] rdata_r;
    reg en_r;
    reg trmd_r;
    reg dir_r;
    reg ckp_r;
    reg dap_r;
    reg [2:0] cks_r;
    reg [7:0] txbuf_r;
    reg [7:0] shift_r;
    reg busy_r;
    reg [3:0] edge_r;
    reg sck_r;
    reg so_r;
    reg [6:0] div_r;
    reg stat_r;
    reg mask_r;
    reg sck_s1_r;
    reg sck_s2_r;
    reg sck_s3_r;
    reg si_s1_r;
    reg si_s2_r;

    // decode
    wire req;
    wire [15:0] idx;
    wire lane0;
    wire wr;
    wire rd;
    wire master;
    wire [6:0] half_lim;
    wire half_tick;
    wire slave_edge;
    wire bit_edge;
    wire sample_edge;
    wire last_edge;
    wire start_tx;
    wire start_rx;
    wire done;
    wire shift_in;
    wire [7:0] shift_nxt;
    wire head_now;
    wire head_tx;

    assign req = wb_cyc_i & wb_stb_i & ~ack_r;
    assign idx = wb_adr_i[17:2];
    assign lane0 = wb_sel_i[0];
    assign wr = req & wb_we_i & lane0;
    assign rd = req & ~wb_we_i;
    assign master = (cks_r != `TWS_CK_SLAVE);

    // ack one cycle after the request is seen, dropped the next cycle
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ack_r <= 1'b0;
        end
        else
        begin
            ack_r <= req;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;

    // read mux, unmapped words read as zero
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata_r <= `TWS_RST_WORD;
        end
        else if (rd)
        begin
            case (idx)
                `TWS_IDX_CTRL: rdata_r <= {24'h00_0000, en_r, trmd_r, 1'b0, dir_r, 3'h0, busy_r};
                `TWS_IDX_CKSEL: rdata_r <= {24'h00_0000, 3'h0, ckp_r, dap_r, cks_r};
                `TWS_IDX_TXBUF: rdata_r <= {24'h00_0000, txbuf_r};
                `TWS_IDX_SHIFT: rdata_r <= {24'h00_0000, shift_r};
                `TWS_IDX_IRQ_STAT: rdata_r <= {31'h0000_0000, stat_r};
                `TWS_IDX_IRQ_MASK: rdata_r <= {31'h0000_0000, mask_r};
                default: rdata_r <= `TWS_RST_WORD;
            endcase
        end
    end

    // control and clock select; bit 5 and unused bits are not stored
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            en_r <= 1'b0;
            trmd_r <= 1'b0;
            dir_r <= 1'b0;
            ckp_r <= 1'b0;
            dap_r <= 1'b0;
            cks_r <= 3'h0;
            txbuf_r <= `TWS_RST_BYTE;
            mask_r <= 1'b0;
        end
        else if (wr)
        begin
            case (idx)
                `TWS_IDX_CTRL:
                begin
                    en_r <= wb_dat_i[`TWS_CTRL_EN];
                    trmd_r <= wb_dat_i[`TWS_CTRL_TRMD];
                    dir_r <= wb_dat_i[`TWS_CTRL_DIR];
                end
                `TWS_IDX_CKSEL:
                begin
                    ckp_r <= wb_dat_i[`TWS_CK_CKP];
                    dap_r <= wb_dat_i[`TWS_CK_DAP];
                    cks_r <= wb_dat_i[`TWS_CK_SEL_HI:`TWS_CK_SEL_LO];
                end
                `TWS_IDX_TXBUF: txbuf_r <= wb_dat_i[7:0];
                `TWS_IDX_IRQ_MASK: mask_r <= wb_dat_i[0];
                default: mask_r <= mask_r;
            endcase
        end
    end

    // pin synchronisers; third clock flop only feeds the edge detector
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sck_s1_r <= 1'b0;
            sck_s2_r <= 1'b0;
            sck_s3_r <= 1'b0;
            si_s1_r <= 1'b0;
            si_s2_r <= 1'b0;
        end
        else
        begin
            sck_s1_r <= serial_clock_pin_i;
            sck_s2_r <= sck_s1_r;
            sck_s3_r <= sck_s2_r;
            si_s1_r <= serial_data_in_pin;
            si_s2_r <= si_s1_r;
        end
    end

    // half-period limit: divide by 2^(n+1) means 2^n clk per half period
    assign half_lim = (7'h01 << cks_r) - 7'h01;
    assign half_tick = busy_r & master & (div_r == half_lim);
    assign slave_edge = busy_r & ~master & (sck_s2_r ^ sck_s3_r);
    assign bit_edge = half_tick | slave_edge;

    // divider restarts with each transfer so the first half period is whole
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            div_r <= 7'h00;
        end
        else if (!busy_r || half_tick)
        begin
            div_r <= 7'h00;
        end
        else
        begin
            div_r <= div_r + 7'h01;
        end
    end

    // even edges are leading, odd trailing; phase picks which one samples
    assign sample_edge = bit_edge & (edge_r[0] == dap_r);
    assign last_edge = bit_edge & (edge_r == `TWS_LAST_EDGE);
    assign start_tx = wr & (idx == `TWS_IDX_TXBUF) & en_r & trmd_r & ~busy_r;
    assign start_rx = rd & (idx == `TWS_IDX_SHIFT) & en_r & ~trmd_r & ~busy_r;
    assign done = last_edge;
    assign shift_in = si_s2_r;

    // bit order for both directions
    assign shift_nxt = dir_r ? {shift_in, shift_r[7:1]} : {shift_r[6:0], shift_in};
    assign head_now = dir_r ? shift_r[0] : shift_r[7];
    assign head_tx = dir_r ? wb_dat_i[0] : wb_dat_i[7];

    // transfer engine; a cleared enable holds everything in reset
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            busy_r <= 1'b0;
            edge_r <= 4'h0;
            shift_r <= `TWS_RST_BYTE;
            so_r <= 1'b0;
        end
        else if (!en_r)
        begin
            busy_r <= 1'b0;
            edge_r <= 4'h0;
            shift_r <= `TWS_RST_BYTE;
            so_r <= 1'b0;
        end
        else if (start_tx)
        begin
            busy_r <= 1'b1;
            edge_r <= 4'h0;
            shift_r <= wb_dat_i[7:0];
            so_r <= head_tx;
        end
        else if (start_rx)
        begin
            busy_r <= 1'b1;
            edge_r <= 4'h0;
        end
        else if (bit_edge)
        begin
            edge_r <= edge_r + 4'h1;
            if (sample_edge)
            begin
                shift_r <= shift_nxt;
            end
            else if (edge_r != `TWS_LAST_EDGE)
            begin
                so_r <= head_now;
            end
            if (last_edge)
            begin
                busy_r <= 1'b0;
            end
        end
    end

    // master clock toggles on every half tick and rests at the polarity level
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sck_r <= 1'b0;
        end
        else if (!busy_r)
        begin
            sck_r <= ckp_r;
        end
        else if (half_tick)
        begin
            sck_r <= ~sck_r;
        end
    end

    // pins: clock driven only when enabled in master mode, else released
    assign serial_clock_pin_o = sck_r;
    assign serial_clock_pin_oe_n = ~(en_r & master);
    assign serial_data_out_pin = so_r & trmd_r;

    // transfer-end status; a new end wins over a same-cycle clear
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stat_r <= 1'b0;
        end
        else if (done)
        begin
            stat_r <= 1'b1;
        end
        else if (wr && idx == `TWS_IDX_IRQ_STAT && wb_dat_i[0])
        begin
            stat_r <= 1'b0;
        end
    end

    // level interrupt while the unmasked status bit is set
    assign irq = stat_r & mask_r;

endmodule

// ---- tws_port_chk.sv ----
// bus and pin checks for the three-wire serial port, bound to its top
// assumes control, clock select and mask change only by wishbone writes
module tws_port_chk (
    // bus
    input wire clk,
    input wire resetn,
    input wire [17:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire [3:0] wb_sel_i,
    input wire wb_we_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    // pins
    input wire irq,
    input wire serial_clock_pin_o,
    input wire serial_clock_pin_oe_n,
    input wire serial_data_out_pin
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    logic [7:0] ctl_r, ck_r, msk_r;
    wire wr = wb_ack_o && wb_we_i && wb_sel_i[0];
    // shadows lag the design by one cycle, so the ack cycle is excluded below except in a_half_period
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
            {ctl_r, ck_r, msk_r} <= 24'h00_0000;
        else if (wr)
        begin
            if (wb_adr_i == 18'h3_fe00) ctl_r <= wb_dat_i[7:0];
            if (wb_adr_i == 18'h3_fe04) ck_r <= wb_dat_i[7:0];
            if (wb_adr_i == 18'h3_fe14) msk_r <= wb_dat_i[7:0];
        end
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_rd;
        wb_ack_o && !wb_we_i;
    endsequence
    a_ack_answer: assert property (s_req |=> wb_ack_o) else $error("no ack after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_upper_zero: assert property (s_rd |-> wb_dat_o[31:8] == 24'h00_0000) else $error("upper read bits set");
    a_ctrl_fixed: assert property (s_rd ##0 wb_adr_i[17:2] == 16'hff80 |->
        !wb_dat_o[5] && wb_dat_o[3:1] == 3'h0) else $error("fixed control bits read nonzero");
    a_dout_low_rx: assert property (!ctl_r[6] && !wb_ack_o |-> !serial_data_out_pin)
        else $error("data out high in receive mode");
    a_oe_off: assert property (!ctl_r[7] && !wb_ack_o |-> serial_clock_pin_oe_n)
        else $error("clock driven while disabled");
    a_half_period: assert property ($changed(serial_clock_pin_o) && ck_r[2:0] == 3'h1 |=>
        $stable(serial_clock_pin_o)) else $error("clock half period short");
    a_irq_masked: assert property (irq && !wb_ack_o |-> msk_r[0]) else $error("irq while masked");
    a_slave_released: assert property (ck_r[2:0] == 3'h7 && !wb_ack_o |-> serial_clock_pin_oe_n)
        else $error("clock driven in slave mode");
endmodule
bind tws_serial_port tws_port_chk u_chk (.clk(clk), .resetn(resetn), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .irq(irq),
    .serial_clock_pin_o(serial_clock_pin_o), .serial_clock_pin_oe_n(serial_clock_pin_oe_n),
    .serial_data_out_pin(serial_data_out_pin));

// ---- tws_periph.sv ----
// peripheral model at the far end of the link, type 1 timing, msb first
// assumes the port is master with the clock idling low
module tws_periph (
    // link pins
    input wire sclk,
    input wire sdo,
    output logic sdi = 1'b0,
    // bench side
    input wire load,
    input wire [7:0] tx_word,
    output logic [7:0] rx_word
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sh_r;
    // new word: first bit stands before the first leading edge
    always @(load)
    begin
        sh_r = tx_word;
        sdi = tx_word[7];
    end
    // leading edge takes the port's bit
    always @(posedge sclk)
        rx_word = {rx_word[6:0], sdo};
    // trailing edge moves on; past the word the line carries the word inverted, as nothing holds it
    always @(negedge sclk)
    begin
        sh_r = {sh_r[6:0], ~sh_r[7]};
        sdi = sh_r[7];
    end
endmodule

// ---- testbench.sv ----
// self-checking bench for the three-wire serial port and its peripheral model
// assumes a one-cycle wishbone answer and a pulled-down clock pin when released
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [17:0] A_CTL = 18'h3_fe00;
    localparam logic [17:0] A_CK = 18'h3_fe04;
    localparam logic [17:0] A_TX = 18'h3_fe08;
    localparam logic [17:0] A_SH = 18'h3_fe0c;
    localparam logic [17:0] A_ST = 18'h3_fe10;
    localparam logic [17:0] A_MK = 18'h3_fe14;
    localparam logic [31:0] Z = 32'h0000_0000;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [17:0] adr = 18'h0_0000;
    logic [31:0] wdat = Z;
    logic [3:0] sel = 4'h0;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic load = 1'b0;
    logic [7:0] ptx = 8'h00;
    logic [31:0] rd;
    wire [31:0] rdat;
    wire [7:0] prx;
    wire ack, irq, sck_o, sck_oe_n, sdo, sdi;
    // released clock pin follows the bench's slave clock, which rests low like a pull-down
    logic slv_sck = 1'b0;
    wire sck = sck_oe_n ? slv_sck : sck_o;
    int errors = 0;
    int n_compared = 0;
    always #20 clk = ~clk;
    tws_serial_port dut (.clk(clk), .resetn(resetn), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack), .irq(irq),
        .serial_clock_pin_i(sck), .serial_clock_pin_o(sck_o), .serial_clock_pin_oe_n(sck_oe_n),
        .serial_data_in_pin(sdi), .serial_data_out_pin(sdo));
    tws_periph peer (.sclk(sck), .sdo(sdo), .sdi(sdi), .load(load), .tx_word(ptx), .rx_word(prx));
    task automatic conclude;
        $display("compared %0d mismatched %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one classic cycle, held until ack is sampled high
    task automatic bus(input logic w, input logic [17:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1)
        begin
            errors++;
            conclude();
        end
    endtask
    // poll the status flag under a bound well above the slowest word
    task automatic wait_idle;
        int n;
        n = 0;
        do
        begin
            bus(1'b0, A_CTL, Z);
            n++;
        end
        while (rd[0] !== 1'b0 && n < 600);
        if (rd[0] !== 1'b0)
        begin
            errors++;
            conclude();
        end
    endtask
    function automatic logic [7:0] rev(input logic [7:0] v);
        return {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
    endfunction
    task automatic t_regs;
        for (int i = 0; i < 7; i++)
        begin
            bus(1'b0, A_CTL + 18'(i * 4), Z);
            check(rd, Z);
        end
        $display("register reset values done");
    endtask
    // full-duplex master word; at the two fastest rates the synced input lags too far to judge
    task automatic t_xfer(input logic dir, input logic [2:0] code, input logic [7:0] d, input logic [7:0] p);
        bus(1'b1, A_CTL, Z);
        bus(1'b1, A_CK, {29'h0000_0000, code});
        bus(1'b1, A_ST, 32'h0000_0001);
        bus(1'b1, A_CTL, {24'h00_0000, 3'h6, dir, 4'h0});
        ptx <= p;
        load <= ~load;
        bus(1'b1, A_TX, {24'h00_0000, d});
        bus(1'b0, A_CTL, Z);
        check(rd, {24'h00_0000, 3'h6, dir, 4'h1});
        wait_idle();
        check({24'h00_0000, prx}, {24'h00_0000, dir ? rev(d) : d});
        bus(1'b0, A_SH, Z);
        if (code > 3'h1) check(rd, {24'h00_0000, dir ? rev(p) : p});
        bus(1'b0, A_ST, Z);
        check(rd, 32'h0000_0001);
        $display("transfer code %0d done", code);
    endtask
    // receive-only word started by a read; a second read leaves a word running
    task automatic t_rx(input logic [7:0] p);
        bus(1'b1, A_CTL, 32'h0000_0080);
        ptx <= p;
        load <= ~load;
        bus(1'b0, A_SH, Z);
        wait_idle();
        bus(1'b0, A_SH, Z);
        check(rd, {24'h00_0000, p});
        $display("receive-only done");
    endtask
    // disable mid-word clears flag and shift register
    task automatic t_off;
        bus(1'b1, A_CTL, Z);
        bus(1'b0, A_CTL, Z);
        check(rd, Z);
        bus(1'b0, A_SH, Z);
        check(rd, Z);
        $display("disable done");
    endtask
    task automatic t_irq;
        bus(1'b1, A_MK, 32'h0000_0001);
        @(negedge clk);
        check({31'h0000_0000, irq}, 32'h0000_0001);
        bus(1'b1, A_MK, Z);
        @(negedge clk);
        check({31'h0000_0000, irq}, Z);
        bus(1'b1, A_MK, 32'h0000_0001);
        bus(1'b1, A_ST, 32'h0000_0001);
        @(negedge clk);
        check({31'h0000_0000, irq}, Z);
        $display("interrupt done");
    endtask
    // slave word: the bench clocks the pin, six clk per half period to cover the sync lag
    task automatic t_slave(input logic [7:0] d, input logic [7:0] p);
        bus(1'b1, A_CTL, Z);
        bus(1'b1, A_CK, 32'h0000_0007);
        bus(1'b1, A_CTL, 32'h0000_00c0);
        @(negedge clk);
        check({31'h0000_0000, sck_oe_n}, 32'h0000_0001);
        ptx <= p;
        load <= ~load;
        bus(1'b1, A_TX, {24'h00_0000, d});
        for (int i = 0; i < 16; i++)
        begin
            repeat (6) @(posedge clk);
            slv_sck <= ~slv_sck;
        end
        wait_idle();
        check({24'h00_0000, prx}, {24'h00_0000, d});
        bus(1'b0, A_SH, Z);
        check(rd, {24'h00_0000, p});
        $display("slave transfer done");
    endtask
    // clock idle level follows polarity; defaults release the clock pin
    task automatic t_pol;
        bus(1'b1, A_CTL, Z);
        bus(1'b1, A_CK, 32'h0000_0018);
        bus(1'b0, A_CK, Z);
        check(rd, 32'h0000_0018);
        @(negedge clk);
        check({31'h0000_0000, sck_o}, 32'h0000_0001);
        bus(1'b1, A_CK, Z);
        @(negedge clk);
        check({31'h0000_0000, sck_o}, Z);
        check({31'h0000_0000, sck_oe_n}, 32'h0000_0001);
        $display("polarity done");
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        t_regs();
        for (int c = 0; c < 7; c++)
            t_xfer(c[0], c[2:0], 8'hc3 ^ 8'(c), 8'h5a ^ 8'(c * 16));
        t_irq();
        t_rx(8'ha5);
        t_off();
        t_slave(8'h96, 8'h3c);
        t_pol();
        conclude();
    end
endmodule
